// ### logic/mlbi_top.sv
/*
  Motion limit selection and holding-brake interlock for a servo drive.
  Assumes: parameter words arrive from the serial parameter handler on
  clk_sys; selector inputs and the emergency stop come from pins; the
  servo-on, alarm, mode and speed inputs come from logic on clk_sys.
*/
// Operation
// R1 - speed always capped at maximum speed parameter
// R2 - selectable speed limit only in torque mode
// R3 - analog torque command frees speed selector pair
// R4 - too few inputs: speed limit from analog
// R5 - limits enforced only when enable equals one
// R6 - selectable torque limit only in position/speed
// R7 - pulse or analog speed frees torque pair
// R8 - too few inputs: torque limit from analog
// R9 - brake released after on-delay past servo-on
// R10 - brake locks after signed off-delay past servo-off
// R11 - brake on digital output via code 0x07
// R12 - slow motor during off-delay locks at once
// R13 - off-delay expiry locks regardless of speed
// R14 - alarm or e-stop: negative off-delay is zero
// R15 - output low locked, high released
// R16 - selector pair zero: analog, else preset
// R17 - brake locked after reset and servo off
// R18 - millisecond ticks; new edge restarts timer
`include "mlbi_defs.svh"
`default_nettype none

module mlbi_top #(
  parameter int TICK_CYC = `MLBI_TICK_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic param_wr_en,
  input wire logic param_rd_en,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  output logic [15:0] param_rdata,
  output logic param_ack,
  input wire mlbi_pkg::mlbi_mode_e op_mode,
  input wire mlbi_pkg::mlbi_src_s cmd_src,
  input wire mlbi_pkg::mlbi_limit_cfg_s limit_cfg,
  input wire logic [15:0] analog_speed_lim,
  input wire logic [15:0] analog_torque_lim,
  input wire logic speed_sel_lo,
  input wire logic speed_sel_hi,
  input wire logic torque_sel_lo,
  input wire logic torque_sel_hi,
  input wire logic emergency_stop_in,
  input wire logic servo_on,
  input wire logic alarm_in,
  input wire logic signed [15:0] motor_speed,
  input wire logic [15:0] brake_speed_threshold,
  input wire logic [7:0] do_func_code,
  output logic [15:0] speed_limit_out,
  output logic speed_limit_active,
  output logic [15:0] torque_limit_out,
  output logic torque_limit_active,
  output logic brake_release,
  output logic do_out,
  output logic power_hold,
  output mlbi_pkg::mlbi_brk_e brake_state
);

  import mlbi_pkg::*;

  localparam int TW = 11;
  localparam int NPIN = 5;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;
  logic [NPIN-1:0] pin_meta_next;
  logic [NPIN-1:0] pin_sync_next;

  assign pin_raw = {emergency_stop_in, torque_sel_hi, torque_sel_lo,
                    speed_sel_hi, speed_sel_lo};

  // two stages; only the second stage is read by logic
  always_comb begin
    pin_meta_next = pin_raw;
    pin_sync_next = pin_meta_reg;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_meta_next;
      pin_sync_reg <= pin_sync_next;
    end
  end

  logic [1:0] spd_sel;
  logic [1:0] trq_sel;
  logic estop;

  assign spd_sel = pin_sync_reg[1:0];
  assign trq_sel = pin_sync_reg[3:2];
  assign estop = pin_sync_reg[4];

  // -----------------------------------------------------------------
  // brake delay parameters
  // -----------------------------------------------------------------
  logic [15:0] on_dly_reg;
  logic [15:0] off_dly_reg;
  logic [15:0] rdata_reg;
  logic ack_reg;
  logic [15:0] on_dly_next;
  logic [15:0] off_dly_next;
  logic [15:0] rdata_next;
  logic ack_next;

  // word write or read; an unknown address reads zero and is still acked
  always_comb begin
    on_dly_next = on_dly_reg;
    off_dly_next = off_dly_reg;
    rdata_next = rdata_reg;
    ack_next = param_wr_en | param_rd_en;
    if (param_wr_en) begin
      if (param_addr == `MLBI_ADDR_ON_DLY) begin
        on_dly_next = param_wdata;
      end
      if (param_addr == `MLBI_ADDR_OFF_DLY) begin
        off_dly_next = param_wdata;
      end
    end
    if (param_rd_en) begin
      if (param_addr == `MLBI_ADDR_ON_DLY) begin
        rdata_next = on_dly_reg;
      end else if (param_addr == `MLBI_ADDR_OFF_DLY) begin
        rdata_next = off_dly_reg;
      end else begin
        rdata_next = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      on_dly_reg <= `MLBI_RST_ON_DLY;
      off_dly_reg <= `MLBI_RST_OFF_DLY;
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
    end else begin
      on_dly_reg <= on_dly_next;
      off_dly_reg <= off_dly_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  assign param_rdata = rdata_reg;
  assign param_ack = ack_reg;

  // -----------------------------------------------------------------
  // limit selection
  // -----------------------------------------------------------------
  logic lim_en;
  logic spd_pair_free;
  logic trq_pair_free;
  logic [15:0] spd_pick;
  logic [15:0] trq_pick;
  logic [15:0] spd_lim_next;
  logic [15:0] trq_lim_next;
  logic spd_act_next;
  logic trq_act_next;
  logic [15:0] spd_lim_reg;
  logic [15:0] trq_lim_reg;
  logic spd_act_reg;
  logic trq_act_reg;

  assign lim_en = (limit_cfg.limit_enable_param == `MLBI_LIMIT_EN_VAL); // [R5]
  assign spd_pair_free = cmd_src.torque_cmd_analog & cmd_src.spare_di_ok; // [R3]
  assign trq_pair_free = (cmd_src.pos_cmd_pulse | cmd_src.speed_cmd_analog)
                         & cmd_src.spare_di_ok; // [R7]

  // speed source: pair 00 or no free pair gives analog [R16] [R4]
  always_comb begin
    spd_pick = analog_speed_lim;
    if (spd_pair_free) begin
      unique case (spd_sel)
        2'b00: spd_pick = analog_speed_lim;
        2'b01: spd_pick = limit_cfg.speed_preset_first;
        2'b10: spd_pick = limit_cfg.speed_preset_mid;
        2'b11: spd_pick = limit_cfg.speed_preset_last;
      endcase
    end
  end

  // torque source, same scheme [R16] [R8]
  always_comb begin
    trq_pick = analog_torque_lim;
    if (trq_pair_free) begin
      unique case (trq_sel)
        2'b00: trq_pick = analog_torque_lim;
        2'b01: trq_pick = limit_cfg.torque_preset_first;
        2'b10: trq_pick = limit_cfg.torque_preset_mid;
        2'b11: trq_pick = limit_cfg.torque_preset_last;
      endcase
    end
  end

  // the maximum-speed cap holds in every mode, limit or not
  always_comb begin
    spd_act_next = lim_en && (op_mode == MLBI_MODE_TORQUE); // [R2]
    trq_act_next = lim_en && (op_mode == MLBI_MODE_POS ||
                              op_mode == MLBI_MODE_SPEED); // [R6]
    spd_lim_next = limit_cfg.max_speed_param; // [R1]
    if (spd_act_next && spd_pick < limit_cfg.max_speed_param) begin
      spd_lim_next = spd_pick; // [R1]
    end
    trq_lim_next = trq_act_next ? trq_pick : 16'hFFFF;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      spd_lim_reg <= 16'h0000;
      trq_lim_reg <= 16'h0000;
      spd_act_reg <= 1'b0;
      trq_act_reg <= 1'b0;
    end else begin
      spd_lim_reg <= spd_lim_next;
      trq_lim_reg <= trq_lim_next;
      spd_act_reg <= spd_act_next;
      trq_act_reg <= trq_act_next;
    end
  end

  assign speed_limit_out = spd_lim_reg;
  assign torque_limit_out = trq_lim_reg;
  assign speed_limit_active = spd_act_reg;
  assign torque_limit_active = trq_act_reg;

  // -----------------------------------------------------------------
  // millisecond tick
  // -----------------------------------------------------------------
  logic [31:0] pre_reg;
  logic [31:0] pre_next;
  logic tick;

  assign tick = (pre_reg == 32'(TICK_CYC - 1));

  // free-running prescaler from the system clock [R18]
  always_comb begin
    pre_next = tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= 32'h0000_0000;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // -----------------------------------------------------------------
  // brake interlock sequence
  // -----------------------------------------------------------------
  mlbi_brk_e st_reg;
  mlbi_brk_e st_next;
  logic srv_d_reg;
  logic srv_d_next;
  logic rel_reg;
  logic rel_next;
  logic do_reg;
  logic do_next;
  logic forced_off;
  logic srv_eff;
  logic srv_rise;
  logic srv_fall;
  logic tmr_load;
  logic [TW-1:0] tmr_val;
  logic tmr_done;
  logic [TW-1:0] on_ms;
  logic [TW-1:0] off_ms;
  logic [15:0] off_mag;
  logic off_neg;
  logic off_zero;
  logic [15:0] spd_abs;
  logic slow;

  assign forced_off = alarm_in | estop;
  assign srv_eff = servo_on & ~forced_off;
  assign srv_rise = srv_eff & ~srv_d_reg;
  assign srv_fall = ~srv_eff & srv_d_reg;
  assign off_neg = off_dly_reg[15];
  assign off_mag = off_neg ? 16'(-off_dly_reg) : off_dly_reg;
  assign off_zero = (off_dly_reg == 16'h0000);
  // delays saturate at the top of their range
  assign on_ms = (on_dly_reg > 16'(`MLBI_DLY_MAX_MS)) ?
                 `MLBI_DLY_MAX_MS : on_dly_reg[TW-1:0];
  assign off_ms = (off_mag > 16'(`MLBI_DLY_MAX_MS)) ?
                  `MLBI_DLY_MAX_MS : off_mag[TW-1:0];
  assign spd_abs = motor_speed[15] ? 16'(-motor_speed) : 16'(motor_speed);
  assign slow = (spd_abs < brake_speed_threshold);

  // one timer serves both waits, as they never overlap
  mlbi_delay_timer #(
    .WIDTH(TW)
  ) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .tick(tick),
    .done(tmr_done)
  );

  // next state; a rising servo edge always restarts the on wait [R18]
  always_comb begin
    st_next = st_reg;
    tmr_load = 1'b0;
    tmr_val = on_ms;
    srv_d_next = srv_eff;
    if (srv_rise) begin
      st_next = MLBI_BRK_ON_WAIT; // [R9]
      tmr_load = 1'b1;
      tmr_val = on_ms;
    end else if (srv_fall) begin
      if (st_reg == MLBI_BRK_ON_WAIT || st_reg == MLBI_BRK_LOCKED) begin
        st_next = MLBI_BRK_LOCKED; // [R17]
      end else if (off_zero || (off_neg && forced_off)) begin
        st_next = MLBI_BRK_LOCKED; // [R14]
      end else if (off_neg) begin
        st_next = MLBI_BRK_PRE_LOCK; // [R10]
        tmr_load = 1'b1;
        tmr_val = off_ms;
      end else begin
        st_next = MLBI_BRK_OFF_WAIT; // [R10]
        tmr_load = 1'b1;
        tmr_val = off_ms;
      end
    end else begin
      unique case (st_reg)
        MLBI_BRK_LOCKED: st_next = MLBI_BRK_LOCKED;
        MLBI_BRK_ON_WAIT: begin
          if (tmr_done) begin
            st_next = MLBI_BRK_RELEASED; // [R9]
          end
        end
        MLBI_BRK_RELEASED: st_next = MLBI_BRK_RELEASED;
        MLBI_BRK_OFF_WAIT: begin
          if (slow) begin
            st_next = MLBI_BRK_LOCKED; // [R12]
          end else if (tmr_done) begin
            st_next = MLBI_BRK_LOCKED; // [R13]
          end
        end
        MLBI_BRK_PRE_LOCK: begin
          if (tmr_done) begin
            st_next = MLBI_BRK_LOCKED; // [R10]
          end
        end
        default: st_next = MLBI_BRK_LOCKED;
      endcase
    end
  end

  // high only while released or still waiting to lock [R15]
  always_comb begin
    rel_next = (st_next == MLBI_BRK_RELEASED) ||
               (st_next == MLBI_BRK_OFF_WAIT); // [R15]
    do_next = (do_func_code == `MLBI_DO_FUNC_BRAKE) && rel_next; // [R11]
  end

  // reset leaves the brake locked [R17]
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= MLBI_BRK_LOCKED;
      srv_d_reg <= 1'b0;
      rel_reg <= 1'b0;
      do_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      srv_d_reg <= srv_d_next;
      rel_reg <= rel_next;
      do_reg <= do_next;
    end
  end

  assign brake_release = rel_reg;
  assign do_out = do_reg;
  // negative delay: brake locks first, power stage keeps torque meanwhile
  assign power_hold = (st_reg == MLBI_BRK_PRE_LOCK);
  assign brake_state = st_reg;

endmodule

`default_nettype wire

// ### logic/mlbi_defs.svh
/*
  Constants for the motion limit and brake interlock block: parameter
  addresses, reset values, codes and timing figures.
  Assumes inclusion by bare name from the top-level design file.
*/
`ifndef MLBI_DEFS_SVH
`define MLBI_DEFS_SVH

// -----------------------------------------------------------------
// parameter addresses and reset values
// -----------------------------------------------------------------
`define MLBI_ADDR_ON_DLY 16'h022A
`define MLBI_ADDR_OFF_DLY 16'h022C
`define MLBI_RST_ON_DLY 16'h0000
`define MLBI_RST_OFF_DLY 16'h0000

// -----------------------------------------------------------------
// codes and limits
// -----------------------------------------------------------------
`define MLBI_LIMIT_EN_VAL 16'h0001
`define MLBI_DO_FUNC_BRAKE 8'h07
`define MLBI_DLY_MAX_MS 11'h3E8

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define MLBI_CLK_HZ 10000000
`define MLBI_TICK_MS 1
`define MLBI_TICK_CYC (`MLBI_CLK_HZ / 1000 * `MLBI_TICK_MS)

`endif

// ### logic/mlbi_pkg.sv
/*
  Types for the motion limit and brake interlock block.
  Assumes mlbi_defs.svh is on the include path.
*/
`default_nettype none

package mlbi_pkg;

  // operating mode of the drive loop
  typedef enum logic [1:0] {
    MLBI_MODE_POS = 2'b00,
    MLBI_MODE_SPEED = 2'b01,
    MLBI_MODE_TORQUE = 2'b10
  } mlbi_mode_e;

  // brake interlock sequence
  typedef enum logic [2:0] {
    MLBI_BRK_LOCKED = 3'b000,
    MLBI_BRK_ON_WAIT = 3'b001,
    MLBI_BRK_RELEASED = 3'b010,
    MLBI_BRK_OFF_WAIT = 3'b011,
    MLBI_BRK_PRE_LOCK = 3'b100
  } mlbi_brk_e;

  // limit parameters held elsewhere in the parameter file
  typedef struct packed {
    logic [15:0] max_speed_param;
    logic [15:0] limit_enable_param;
    logic [15:0] speed_preset_first;
    logic [15:0] speed_preset_mid;
    logic [15:0] speed_preset_last;
    logic [15:0] torque_preset_first;
    logic [15:0] torque_preset_mid;
    logic [15:0] torque_preset_last;
  } mlbi_limit_cfg_s;

  // command source situation that decides whether spare inputs exist
  typedef struct packed {
    logic torque_cmd_analog;
    logic pos_cmd_pulse;
    logic speed_cmd_analog;
    logic spare_di_ok;
  } mlbi_src_s;

endpackage

`default_nettype wire

// ### logic/mlbi_delay_timer.sv
/*
  Millisecond down-counter for the brake delays.
  Assumes a one-cycle tick per millisecond from the same clock.
*/
`default_nettype none

module mlbi_delay_timer #(
  parameter int WIDTH = 11
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  input wire logic tick,
  output logic done
);

  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  // -----------------------------------------------------------------
  // count
  // -----------------------------------------------------------------
  // load restarts the wait even mid-count [R18]
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (tick && cnt_reg != '0) begin
      cnt_next = cnt_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // first tick may come early, so a wait is up to one ms short
  assign done = (cnt_reg == '0) && !load;

endmodule

`default_nettype wire

// ### dv/mlbi_top_asserts.sv
/*
  Checker for mlbi_top: parameter-bus answer, brake sequence, limit gating.
  Assumes binding onto mlbi_top and a single clk_sys domain.
*/
`default_nettype none

module mlbi_top_asserts
  import mlbi_pkg::*;
#(
  parameter int TICK_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic param_wr_en,
  input wire logic param_rd_en,
  input wire logic [15:0] param_addr,
  input wire logic [15:0] param_wdata,
  input wire logic [15:0] param_rdata,
  input wire logic param_ack,
  input wire mlbi_mode_e op_mode,
  input wire mlbi_src_s cmd_src,
  input wire mlbi_limit_cfg_s limit_cfg,
  input wire logic [15:0] analog_speed_lim,
  input wire logic [15:0] analog_torque_lim,
  input wire logic speed_sel_lo,
  input wire logic speed_sel_hi,
  input wire logic torque_sel_lo,
  input wire logic torque_sel_hi,
  input wire logic emergency_stop_in,
  input wire logic servo_on,
  input wire logic alarm_in,
  input wire logic signed [15:0] motor_speed,
  input wire logic [15:0] brake_speed_threshold,
  input wire logic [7:0] do_func_code,
  input wire logic [15:0] speed_limit_out,
  input wire logic speed_limit_active,
  input wire logic [15:0] torque_limit_out,
  input wire logic torque_limit_active,
  input wire logic brake_release,
  input wire logic do_out,
  input wire logic power_hold,
  input wire mlbi_brk_e brake_state
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  // -----------------------------------------------------------------
  // brake sequence steps
  // -----------------------------------------------------------------
  sequence s_servo_rise;
    servo_on && !$past(servo_on) && !alarm_in && brake_state == MLBI_BRK_LOCKED;
  endsequence
  sequence s_slow_in_off;
    brake_state == MLBI_BRK_OFF_WAIT && !motor_speed[15] &&
      {1'b0, motor_speed[14:0]} < brake_speed_threshold;
  endsequence
  property p_rise_waits;
    s_servo_rise |=> brake_state == MLBI_BRK_ON_WAIT;
  endproperty
  property p_slow_locks;
    s_slow_in_off |-> ##[1:2] brake_state == MLBI_BRK_LOCKED;
  endproperty

  a_rise_waits: assert property (p_rise_waits)
    else $error("servo-on edge did not start the on wait");
  a_slow_locks: assert property (p_slow_locks)
    else $error("slow motor during off wait did not lock");
  a_abort_locks: assert property ($fell(servo_on) && brake_state == MLBI_BRK_ON_WAIT
    |=> brake_state == MLBI_BRK_LOCKED) else $error("servo-off in on wait did not lock");
  a_release_map: assert property (brake_release ==
    (brake_state inside {MLBI_BRK_RELEASED, MLBI_BRK_OFF_WAIT}))
    else $error("brake output disagrees with state");
  a_hold_map: assert property (power_hold == (brake_state == MLBI_BRK_PRE_LOCK))
    else $error("power hold disagrees with state");
  a_do_map: assert property (do_out == (brake_release && $past(do_func_code) == 8'h07))
    else $error("digital output wrong for function code");
  a_limit_off: assert property (limit_cfg.limit_enable_param != 16'h0001
    |=> !speed_limit_active && !torque_limit_active && torque_limit_out == 16'hFFFF)
    else $error("limit active while disabled");
  a_speed_mode: assert property (op_mode != MLBI_MODE_TORQUE
    |=> !speed_limit_active && speed_limit_out == $past(limit_cfg.max_speed_param))
    else $error("speed limit outside torque mode");
  a_torque_mode: assert property (op_mode == MLBI_MODE_TORQUE |=> !torque_limit_active)
    else $error("torque limit in torque mode");
  a_speed_cap: assert property ($past(resetn) |->
    speed_limit_out <= $past(limit_cfg.max_speed_param)) else $error("speed above maximum");
  a_ack_pulse: assert property ((param_wr_en || param_rd_en) |=> param_ack)
    else $error("no acknowledge after strobe");
  a_ack_cause: assert property (param_ack |-> $past(param_wr_en || param_rd_en))
    else $error("acknowledge without strobe");
endmodule

bind mlbi_top mlbi_top_asserts #(.TICK_CYC(TICK_CYC)) mlbi_top_asserts_inst (.*);

`default_nettype wire

// ### dv/mlbi_brake_model.sv
/*
  Far-side model: holding brake on the motor shaft.
  Assumes the bench sets the coasting speed through spin.
*/
`default_nettype none

module mlbi_brake_model (
  input wire logic brake_release,
  input wire logic [15:0] spin,
  output logic signed [15:0] motor_speed
);
  timeunit 1ns;
  timeprecision 1ns;
  // locked brake holds the shaft still, released lets it run
  assign motor_speed = brake_release ? $signed(spin) : 16'sh0000;
endmodule

`default_nettype wire

// ### dv/tb_motion_limit_brake_interlock.sv
/*
  Self-checking bench for mlbi_top: parameter access, limit selection, brake.
  Assumes mlbi_pkg, the checker and the brake model are compiled first.
*/
`default_nettype none

module tb_motion_limit_brake_interlock;
  timeunit 1ns;
  timeprecision 1ns;
  import mlbi_pkg::*;
  logic clk_sys, resetn, param_wr_en, param_rd_en, param_ack, speed_sel_lo, speed_sel_hi;
  logic torque_sel_lo, torque_sel_hi, emergency_stop_in, servo_on, alarm_in;
  logic speed_limit_active, torque_limit_active, brake_release, do_out, power_hold;
  logic [15:0] param_addr, param_wdata, param_rdata, analog_speed_lim, analog_torque_lim;
  logic [15:0] brake_speed_threshold, speed_limit_out, torque_limit_out, spin, lfsr, mx, pk;
  logic signed [15:0] motor_speed;
  logic [7:0] do_func_code;
  logic [16:0] e;
  mlbi_mode_e op_mode;
  mlbi_src_s cmd_src;
  mlbi_limit_cfg_s limit_cfg;
  mlbi_brk_e brake_state;
  logic [16:0] expq[$];
  int miscompares, checks, n;

  mlbi_top #(.TICK_CYC(10)) mlbi_top_inst (.*);
  mlbi_brake_model mlbi_brake_model_inst (
    .brake_release(brake_release),
    .spin(spin),
    .motor_speed(motor_speed)
  );

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // one strobe per word; a spare cycle keeps strobes from merging
  task automatic pio(input logic rd, input logic [15:0] a, input logic [15:0] d,
                     input logic [15:0] ex);
    @(negedge clk_sys);
    param_rd_en = rd;
    param_wr_en = !rd;
    param_addr = a;
    param_wdata = d;
    expq.push_back({rd, ex});
    @(negedge clk_sys);
    param_rd_en = 0;
    param_wr_en = 0;
  endtask
  // bounded wait for the brake output to reach a level
  task automatic wait_brk(input logic v, input int lim);
    n = 0;
    while (brake_release !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (brake_release !== v) begin
      miscompares++;
      finish_test();
    end
  endtask

  // clock and hang guard
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end

  // watcher: every acknowledge retires the oldest note
  always @(posedge clk_sys) begin
    #1;
    if (param_ack === 1'b1) begin
      if (expq.size() == 0) check(16'h0001, 16'h0000, "stray ack");
      else begin
        e = expq.pop_front();
        if (e[16]) check(param_rdata, e[15:0], "param_rdata");
      end
    end
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    {resetn, param_wr_en, param_rd_en, speed_sel_lo, speed_sel_hi} = '0;
    {torque_sel_lo, torque_sel_hi, emergency_stop_in, servo_on, alarm_in} = '0;
    {param_addr, param_wdata, analog_speed_lim, analog_torque_lim, spin} = '0;
    brake_speed_threshold = 16'h0100;
    do_func_code = 8'h07;
    op_mode = MLBI_MODE_POS;
    cmd_src = '0;
    limit_cfg = '0;
    lfsr = 16'h0018;
    miscompares = 0;
    checks = 0;
    cyc(12);
    resetn = 1;
    check(16'(brake_state), 16'(MLBI_BRK_LOCKED), "reset state");
    pio(1, 16'h022A, 16'h0000, 16'h0000);
    pio(1, 16'h022C, 16'h0000, 16'h0000);
    pio(0, 16'h022A, 16'h0003, 16'h0000);
    pio(0, 16'h022C, 16'h0005, 16'h0000);
    pio(0, 16'h022B, 16'h1234, 16'h0000);
    pio(1, 16'h022A, 16'h0000, 16'h0003);
    pio(1, 16'h022C, 16'h0000, 16'h0005);
    pio(1, 16'h022B, 16'h0000, 16'h0000);
    // every selector code, with and without spare inputs
    for (int s = 0; s < 4; s++) begin
      limit_cfg = {rnd(), 16'h0001, rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      analog_speed_lim = rnd();
      analog_torque_lim = rnd();
      mx = limit_cfg.max_speed_param;
      {speed_sel_hi, speed_sel_lo} = 2'(s);
      {torque_sel_hi, torque_sel_lo} = 2'(s);
      op_mode = MLBI_MODE_TORQUE;
      cmd_src = 4'b1001;
      cyc(4);
      pk = s == 0 ? analog_speed_lim : s == 1 ? limit_cfg.speed_preset_first :
           s == 2 ? limit_cfg.speed_preset_mid : limit_cfg.speed_preset_last;
      check(speed_limit_out, pk < mx ? pk : mx, "spd pick");
      check(16'(speed_limit_active), 16'h0001, "spd act");
      cmd_src = 4'b1000;
      cyc(2);
      check(speed_limit_out, analog_speed_lim < mx ? analog_speed_lim : mx, "spd an");
      op_mode = s[0] ? MLBI_MODE_POS : MLBI_MODE_SPEED;
      cmd_src = s[0] ? 4'b0101 : 4'b0011;
      cyc(2);
      pk = s == 0 ? analog_torque_lim : s == 1 ? limit_cfg.torque_preset_first :
           s == 2 ? limit_cfg.torque_preset_mid : limit_cfg.torque_preset_last;
      check(torque_limit_out, pk, "trq pick");
      check(16'(torque_limit_active), 16'h0001, "trq act");
      check(speed_limit_out, mx, "spd idle");
      cmd_src = 4'b0010;
      cyc(2);
      check(torque_limit_out, analog_torque_lim, "trq an");
      limit_cfg.limit_enable_param = 16'(s * 2);
      cyc(2);
      check(torque_limit_out, 16'hFFFF, "trq off");
    end
    // on delay, output code, slow-motor lock
    spin = 16'h0800;
    servo_on = 1;
    cyc(15);
    check(16'(brake_release), 16'h0000, "on early");
    wait_brk(1, 25);
    // 3 ms wait: one early tick allowed, plus two cycles of edge and state latency
    check(16'(n + 15 >= 20 && n + 15 <= 32), 16'h0001, "on delay");
    check(16'(do_out), 16'h0001, "do on");
    do_func_code = 8'h05;
    cyc(2);
    check(16'(do_out), 16'h0000, "do other");
    do_func_code = 8'h07;
    servo_on = 0;
    cyc(20);
    check(16'(brake_release), 16'h0001, "off hold");
    spin = 16'h0010;
    wait_brk(0, 3);
    // off delay expiry with a fast motor
    spin = 16'h0800;
    servo_on = 1;
    wait_brk(1, 40);
    servo_on = 0;
    cyc(38);
    check(16'(brake_release), 16'h0001, "off early");
    wait_brk(0, 15);
    // negative off delay: normal stop, then alarm and emergency stop
    pio(0, 16'h022C, 16'hFFFC, 16'h0000);
    servo_on = 1;
    wait_brk(1, 40);
    servo_on = 0;
    wait_brk(0, 3);
    cyc(1);
    check(16'(power_hold), 16'h0001, "neg hold");
    cyc(45);
    check(16'(power_hold), 16'h0000, "neg end");
    for (int i = 0; i < 2; i++) begin
      servo_on = 1;
      wait_brk(1, 40);
      alarm_in = i == 0;
      emergency_stop_in = i == 1;
      wait_brk(0, 6);
      cyc(1);
      check(16'(power_hold), 16'h0000, "fault stop");
      {alarm_in, emergency_stop_in, servo_on} = '0;
      cyc(4);
    end
    // servo-off inside the on wait
    servo_on = 1;
    cyc(5);
    servo_on = 0;
    cyc(2);
    check(16'(brake_state), 16'(MLBI_BRK_LOCKED), "abort");
    cyc(4);
    finish_test();
  end
endmodule

`default_nettype wire
